// ### design/gp_timer_pkg.sv
// package for the general timer channel: register map, fields, reset values
// assumes a 32-bit axi4-lite register bus, one register per aligned word
package gp_timer_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;   // run flag and options
    localparam logic [7:0] OFF_MODE = 8'h04;   // mode register
    localparam logic [7:0] OFF_COUNT = 8'h08;  // count: read counter, write reload
    localparam logic [7:0] OFF_STAT = 8'h0C;   // status: reload and output level
    // ctrl fields
    localparam int CTRL_RUN = 0;
    localparam int CTRL_GATE_EN = 1;
    localparam int CTRL_GATE_LVL = 2;
    localparam int CTRL_PULSE_EN = 3;
    localparam int CTRL_FREE_RUN = 4;
    localparam int CTRL_UP = 5;
    localparam int CTRL_DIR_PIN = 6;
    localparam int CTRL_EDGE_FALL = 7;
    localparam int CTRL_SRC_LO = 8;
    localparam int CTRL_SRC_W = 2;
    // mode field: two low bits of the mode register
    localparam int MODE_W = 2;
    localparam logic [1:0] MODE_INTERVAL = 2'h0;
    localparam logic [1:0] MODE_EVENT = 2'h1;
    // internal clock selects
    localparam logic [1:0] SRC_DIV1 = 2'h0;
    localparam logic [1:0] SRC_DIV8 = 2'h1;
    localparam logic [1:0] SRC_DIV32 = 2'h2;
    localparam logic [1:0] SRC_SUB32 = 2'h3;
    // event source select (same field in event mode)
    localparam logic [1:0] EVT_PIN = 2'h0;
    localparam logic [1:0] EVT_GRP2 = 2'h1;
    localparam logic [1:0] EVT_NEIGH = 2'h2;
    // divider tap counts
    localparam logic [4:0] DIV8_LAST = 5'h07;
    localparam logic [4:0] DIV32_LAST = 5'h1F;
    // reset values
    localparam logic [15:0] COUNT_RST = 16'hFFFF;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### design/gp_timer.sv
// one 16-bit general timer channel: interval-timer and single-phase event modes
// assumes: axi4-lite master on i_mclk; pins and sub clock are asynchronous
// Operation
// - interval mode counts div1, div8, div32, subclk div32
// - interval counts down, reloads on underflow
// - interval underflow period is n plus one
// - counting only while run flag set
// - interval mode requests interrupt on underflow
// - count read returns live counter
// - stopped write loads reload and counter
// - running write loads reload only
// - gate pin level enables interval counting
// - pulse output toggles on each underflow
// - event counts pin edges or timer overflows
// - direction by software or output pin
// - event mode reloads on wrap unless free-run
// - up period is ffff minus n plus one
// - down period is n plus one
// - event mode requests interrupt on wrap
// - free-run wraps without reload
// - pulse output toggles on event wrap
// - output pin is port, pulse, or direction
// - channels one and two have no pins
// - this channel does single-phase counting only
// - mode from two low mode bits
// - counter and reload are 16 bits
//
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/10ps
module gp_timer
    import gp_timer_pkg::*;
#(
    parameter int CHANNEL = 0,       // channel index 0..4
    parameter int WIDTH = 16         // counter width
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_b,
    // axi4-lite write address and data
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [7:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    // axi4-lite read
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [7:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    // pins and neighbour events
    input wire logic i_channel_input_pin,
    input wire logic i_channel_output_pin,
    output logic o_channel_output_pin,
    output logic o_channel_output_pin_oe,
    input wire logic i_subclk,
    input wire logic i_second_group_timer_two,
    input wire logic i_neighbour_channel,
    // wrap pulse for other channels and interrupt request
    output logic o_wrap,
    output logic o_irq
);
    // elaboration check: only the 16-bit counter and channels 0..4 are served
    if (WIDTH != 16 || CHANNEL < 0 || CHANNEL > 4) begin : g_bad_param
        $error("gp_timer: unsupported WIDTH or CHANNEL");
    end
    localparam bit HAS_PINS = (CHANNEL != 1) && (CHANNEL != 2);
    localparam logic [WIDTH-1:0] CNT_MAX = '1;

    // byte-laned merge of a write into a word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[8*b +: 8] = d[8*b +: 8];
            end
        end
        return r;
    endfunction

    // --- synchronisers: three flops, change accepted when 2nd and 3rd agree
    logic [2:0] sync_in, sync_dir, sync_sub;     // stage chains
    logic [2:0] next_sync_in, next_sync_dir, next_sync_sub;
    logic in_lvl, dir_lvl, sub_lvl;              // filtered levels
    logic next_in_lvl, next_dir_lvl, next_sub_lvl;
    // filter: change counted once stages 2 and 3 agree
    always_comb begin
        next_sync_in = {sync_in[1:0], i_channel_input_pin & HAS_PINS};
        next_sync_dir = {sync_dir[1:0], i_channel_output_pin & HAS_PINS};
        next_sync_sub = {sync_sub[1:0], i_subclk};
        next_in_lvl = (sync_in[1] == sync_in[2]) ? sync_in[2] : in_lvl;
        next_dir_lvl = (sync_dir[1] == sync_dir[2]) ? sync_dir[2] : dir_lvl;
        next_sub_lvl = (sync_sub[1] == sync_sub[2]) ? sync_sub[2] : sub_lvl;
    end
    // synchroniser registers
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sync_in <= 3'h0;
            sync_dir <= 3'h0;
            sync_sub <= 3'h0;
            in_lvl <= 1'b0;
            dir_lvl <= 1'b0;
            sub_lvl <= 1'b0;
        end else begin
            sync_in <= next_sync_in;
            sync_dir <= next_sync_dir;
            sync_sub <= next_sync_sub;
            in_lvl <= next_in_lvl;
            dir_lvl <= next_dir_lvl;
            sub_lvl <= next_sub_lvl;
        end
    end

    // --- registers
    logic [31:0] ctrl;               // control bits
    logic [MODE_W-1:0] mode;         // operating mode
    logic [WIDTH-1:0] reload;        // reload register
    logic [WIDTH-1:0] count;         // live counter
    logic out_lvl;                   // pulse output level
    logic [4:0] div8_cnt, div32_cnt, sub_cnt;  // prescalers
    logic sub_prev;                  // last filtered sub clock
    logic in_prev;                   // last filtered input pin
    logic [31:0] next_ctrl;
    logic [MODE_W-1:0] next_mode;
    logic [WIDTH-1:0] next_reload, next_count;
    logic next_out_lvl, next_sub_prev, next_in_prev;
    logic [4:0] next_div8_cnt, next_div32_cnt, next_sub_cnt;

    // decoded control
    logic run, is_event, up, tick, wr_count, wrap;
    logic [1:0] src;
    logic wr_fire;                   // write accepted this cycle
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [31:0] mode_word, count_word;  // write images merged by byte lane

    // count source selection and step
    always_comb begin
        run = ctrl[CTRL_RUN];
        is_event = (mode == MODE_EVENT);
        src = ctrl[CTRL_SRC_LO +: CTRL_SRC_W];
        up = is_event && (ctrl[CTRL_DIR_PIN] && HAS_PINS ? dir_lvl : ctrl[CTRL_UP]);
        next_div8_cnt = (div8_cnt == DIV8_LAST) ? 5'h00 : div8_cnt + 5'h01;
        next_div32_cnt = (div32_cnt == DIV32_LAST) ? 5'h00 : div32_cnt + 5'h01;
        next_sub_prev = sub_lvl;
        next_in_prev = in_lvl;
        next_sub_cnt = sub_cnt;
        if (sub_lvl && !sub_prev) begin
            next_sub_cnt = (sub_cnt == DIV32_LAST) ? 5'h00 : sub_cnt + 5'h01;
        end
        tick = 1'b0;
        if (!is_event) begin
            unique case (src)
                SRC_DIV1: tick = 1'b1;
                SRC_DIV8: tick = (div8_cnt == DIV8_LAST);
                SRC_DIV32: tick = (div32_cnt == DIV32_LAST);
                SRC_SUB32: tick = sub_lvl && !sub_prev && (sub_cnt == DIV32_LAST);
            endcase
            if (ctrl[CTRL_GATE_EN] && HAS_PINS && (in_lvl != ctrl[CTRL_GATE_LVL])) begin
                tick = 1'b0;
            end
        end else begin
            unique case (src)
                EVT_PIN: tick = HAS_PINS && (ctrl[CTRL_EDGE_FALL] ? (in_prev && !in_lvl)
                                                                 : (!in_prev && in_lvl));
                EVT_GRP2: tick = i_second_group_timer_two;
                EVT_NEIGH: tick = i_neighbour_channel;
                default: tick = 1'b0;
            endcase
        end
        tick = tick && run;
        // wrap: underflow from zero down, overflow from all ones up
        wrap = tick && (up ? (count == CNT_MAX) : (count == '0));
    end

    // counter, reload, output and register writes
    always_comb begin
        next_ctrl = ctrl;
        next_mode = mode;
        next_reload = reload;
        next_count = count;
        next_out_lvl = out_lvl;
        wr_count = wr_fire && (wr_addr == OFF_COUNT);
        mode_word = merge(32'h0000_0000, wr_data, wr_strb);
        count_word = merge({16'h0000, reload}, wr_data, wr_strb);
        if (tick) begin
            if (wrap) begin
                // interval always reloads; event reloads unless free-run
                if (!is_event || !ctrl[CTRL_FREE_RUN]) begin
                    next_count = reload;
                end else begin
                    next_count = up ? '0 : CNT_MAX;
                end
                if (ctrl[CTRL_PULSE_EN]) begin
                    next_out_lvl = !out_lvl;
                end
            end else begin
                next_count = up ? count + 16'h0001 : count - 16'h0001;
            end
        end
        if (wr_fire && wr_addr == OFF_CTRL) begin
            next_ctrl = merge(ctrl, wr_data, wr_strb);
        end
        if (wr_fire && wr_addr == OFF_MODE) begin
            next_mode = mode_word[MODE_W-1:0];
        end
        if (wr_count) begin
            next_reload = count_word[WIDTH-1:0];
            if (!run) begin
                next_count = count_word[WIDTH-1:0];
            end
        end
    end

    // timer state registers
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ctrl <= CTRL_RST;
            mode <= MODE_INTERVAL;
            reload <= COUNT_RST;
            count <= COUNT_RST;
            out_lvl <= 1'b0;
            div8_cnt <= 5'h00;
            div32_cnt <= 5'h00;
            sub_cnt <= 5'h00;
            sub_prev <= 1'b0;
            in_prev <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            mode <= next_mode;
            reload <= next_reload;
            count <= next_count;
            out_lvl <= next_out_lvl;
            div8_cnt <= next_div8_cnt;
            div32_cnt <= next_div32_cnt;
            sub_cnt <= next_sub_cnt;
            sub_prev <= next_sub_prev;
            in_prev <= next_in_prev;
        end
    end

    // pins, wrap pulse and interrupt request, all registered
    logic next_pin_oe;
    always_comb begin
        // pulse drives the pin; direction-input use or plain port releases it
        next_pin_oe = HAS_PINS && ctrl[CTRL_PULSE_EN] && !(is_event && ctrl[CTRL_DIR_PIN]);
    end
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_channel_output_pin <= 1'b0;
            o_channel_output_pin_oe <= 1'b0;
            o_wrap <= 1'b0;
            o_irq <= 1'b0;
        end else begin
            o_channel_output_pin <= next_out_lvl;
            o_channel_output_pin_oe <= next_pin_oe;
            o_wrap <= wrap;
            o_irq <= wrap;
        end
    end

    // --- axi4-lite write: take aw and w in either order, respond after both
    logic aw_held, w_held;
    logic next_aw_held, next_w_held, next_bvalid;
    logic [1:0] next_bresp;
    logic [7:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = o_bvalid;
        next_bresp = o_bresp;
        if (i_awvalid && o_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = i_awaddr;
        end
        if (i_wvalid && o_wready) begin
            next_w_held = 1'b1;
            next_w_data = i_wdata;
            next_w_strb = i_wstrb;
        end
        wr_fire = aw_held && w_held && !o_bvalid;
        wr_addr = aw_addr;
        wr_data = w_data;
        wr_strb = w_strb;
        if (wr_fire) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = (aw_addr == OFF_CTRL || aw_addr == OFF_MODE || aw_addr == OFF_COUNT)
                         ? RESP_OKAY : RESP_SLVERR;
        end else if (o_bvalid && i_bready) begin
            next_bvalid = 1'b0;
        end
    end
    // write channel registers
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            o_awready <= 1'b0;
            o_wready <= 1'b0;
            o_bvalid <= 1'b0;
            o_bresp <= RESP_OKAY;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            o_awready <= !next_aw_held && !next_bvalid && !(i_awvalid && o_awready);
            o_wready <= !next_w_held && !next_bvalid && !(i_wvalid && o_wready);
            o_bvalid <= next_bvalid;
            o_bresp <= next_bresp;
        end
    end

    // --- axi4-lite read: status shows reload value and pulse output level
    logic next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    always_comb begin
        next_rvalid = o_rvalid;
        next_rdata = o_rdata;
        next_rresp = o_rresp;
        if (i_arvalid && o_arready) begin
            next_rvalid = 1'b1;
            next_rresp = RESP_OKAY;
            unique case (i_araddr)
                OFF_CTRL: next_rdata = ctrl;
                OFF_MODE: next_rdata = {30'h0000_0000, mode};
                OFF_COUNT: next_rdata = {16'h0000, count};
                OFF_STAT: next_rdata = {15'h0000, out_lvl, reload};
                default: begin
                    next_rdata = 32'h0000_0000;
                    next_rresp = RESP_SLVERR;
                end
            endcase
        end else if (o_rvalid && i_rready) begin
            next_rvalid = 1'b0;
        end
    end
    // read channel registers
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_rresp <= RESP_OKAY;
        end else begin
            o_arready <= !next_rvalid && !(i_arvalid && o_arready);
            o_rvalid <= next_rvalid;
            o_rdata <= next_rdata;
            o_rresp <= next_rresp;
        end
    end

    // --- checks
    a_run_stops: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        !$past(run) && !$past(wr_count) |-> count == $past(count))
        else $error("counter moved while stopped");
    a_irq_on_wrap: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        wrap |=> o_irq)
        else $error("wrap without interrupt request");
    a_wrap_reload: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        wrap && !(is_event && ctrl[CTRL_FREE_RUN]) && !wr_count |=> count == $past(reload))
        else $error("no reload at wrap");
    a_free_wrap: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        wrap && is_event && ctrl[CTRL_FREE_RUN] && !up && !wr_count |=> count == 16'hFFFF)
        else $error("free-run did not wrap");
    a_pulse_flip: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        wrap && ctrl[CTRL_PULSE_EN] |=> o_channel_output_pin != $past(o_channel_output_pin))
        else $error("output pin did not toggle");
    a_stop_write: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        wr_count && !run && wr_strb == 4'hF |=> count == $past(wr_data[15:0]))
        else $error("stopped write missed counter");
    a_run_write: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        wr_count && run && !tick |=> count == $past(count))
        else $error("running write touched counter");
    a_div1_step: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        run && !is_event && src == SRC_DIV1 && !ctrl[CTRL_GATE_EN] && count > 16'h0001
        && !wr_count |=> count == $past(count) - 16'h0001)
        else $error("div1 count step wrong");
    c_interval_wrap: cover property (@(posedge i_mclk) disable iff (!i_rst_b) wrap && !is_event);
    c_event_up: cover property (@(posedge i_mclk) disable iff (!i_rst_b) wrap && up);
    c_run_write: cover property (@(posedge i_mclk) disable iff (!i_rst_b) wr_count && run);
endmodule // gp_timer

// ### test/gp_timer_pins.sv
// model of the parts around the timer pins: pulse source, gate level, direction load, events
// assumes the bench calls its tasks right after a rising edge of i_mclk
`timescale 1ns/10ps
module gp_timer_pins (
    // clock
    input wire logic i_mclk,
    // output pin drive from the channel
    input wire logic i_out_lvl,
    input wire logic i_out_oe,
    // levels and pulses towards the channel
    output logic o_in_pin,
    output logic o_out_pin,
    output logic o_grp2,
    output logic o_neigh
);
    logic dir_lvl; // level the load drives while the channel lets go
    initial begin
        o_in_pin = 1'b0;
        o_grp2 = 1'b0;
        o_neigh = 1'b0;
        dir_lvl = 1'b1;
    end
    // pin read-back: the channel wins while it drives
    assign o_out_pin = i_out_oe ? i_out_lvl : dir_lvl;
    // each half held four cycles so the synchroniser sees every edge
    task automatic pulse(input int n);
        repeat (n) begin
            o_in_pin <= 1'b1;
            repeat (4) @(posedge i_mclk);
            o_in_pin <= 1'b0;
            repeat (4) @(posedge i_mclk);
        end
    endtask
    // level the load drives on the released output pin
    task automatic set_dir(input logic v);
        dir_lvl <= v;
        @(posedge i_mclk);
    endtask
    // steady gate level
    task automatic set_lvl(input logic v);
        o_in_pin <= v;
        @(posedge i_mclk);
    endtask
    // one-cycle overflow pulse from a neighbour (1) or the group-two timer (0)
    task automatic tick(input logic neigh);
        if (neigh) o_neigh <= 1'b1;
        else o_grp2 <= 1'b1;
        @(posedge i_mclk);
        o_neigh <= 1'b0;
        o_grp2 <= 1'b0;
        @(posedge i_mclk);
    endtask
endmodule // gp_timer_pins

// ### test/gp_timer_tb_top.sv
// self-checking bench for the timer channel in interval and event modes
// assumes gp_timer_pkg and the pin model gp_timer_pins are compiled first
`timescale 1ns/10ps
module gp_timer_tb_top;
    import gp_timer_pkg::*;
    // bus and pin signals
    logic mclk, rst_b, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, wrap, irq, subclk;
    logic in_pin, out_in, out_pin, out_oe, grp2, neigh, last_pin;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rv, a;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rr;
    int failures = 0, samples_checked = 0, cyc = 0, wraps = 0, irqs = 0, flips = 0;
    int per, w0, f0;
    localparam int LIMIT = 20000;
    localparam logic [31:0] RUN = 32'h1 << CTRL_RUN;
    localparam logic [31:0] GATE = (32'h1 << CTRL_GATE_EN) | (32'h1 << CTRL_GATE_LVL);
    localparam logic [31:0] PULSE = 32'h1 << CTRL_PULSE_EN;
    localparam logic [31:0] FREE = 32'h1 << CTRL_FREE_RUN;
    localparam logic [31:0] UP = 32'h1 << CTRL_UP;
    localparam logic [31:0] DIRP = 32'h1 << CTRL_DIR_PIN;
    gp_timer dut_u (.i_mclk(mclk), .i_rst_b(rst_b), .i_awvalid(awvalid), .o_awready(awready),
        .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata),
        .i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
        .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid),
        .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp), .i_channel_input_pin(in_pin),
        .i_channel_output_pin(out_in), .o_channel_output_pin(out_pin),
        .o_channel_output_pin_oe(out_oe), .i_subclk(subclk), .i_second_group_timer_two(grp2),
        .i_neighbour_channel(neigh), .o_wrap(wrap), .o_irq(irq));
    gp_timer_pins pins_u (.i_mclk(mclk), .i_out_lvl(out_pin), .i_out_oe(out_oe),
        .o_in_pin(in_pin), .o_out_pin(out_in), .o_grp2(grp2), .o_neigh(neigh));
    // 20 MHz clock
    initial mclk = 1'b0;
    always #25 mclk = ~mclk;
    // counts wraps, requests and pin flips; cuts a hang short
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        subclk <= cyc[1];
        if (wrap === 1'b1) wraps <= wraps + 1;
        if (irq === 1'b1) irqs <= irqs + 1;
        if (out_pin !== last_pin) flips <= flips + 1;
        last_pin <= out_pin;
        if (cyc == LIMIT) begin
            failures++;
            give_verdict;
        end
    end
    task automatic give_verdict;
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    // axi4-lite write, response code left in rr
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge mclk);
        awvalid <= 1'b1;
        awaddr <= ad;
        wvalid <= 1'b1;
        wdata <= d;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge mclk);
            if (!aw_ok && awready === 1'b1) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready === 1'b1) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge mclk); while (bvalid !== 1'b1);
        rr = bresp;
        bready <= 1'b0;
    endtask
    // axi4-lite read into rv and rr
    task automatic rd(input logic [7:0] ad);
        @(posedge mclk);
        arvalid <= 1'b1;
        araddr <= ad;
        rready <= 1'b1;
        do @(posedge mclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge mclk); while (rvalid !== 1'b1);
        rv = rdata;
        rr = rresp;
        rready <= 1'b0;
    endtask
    // cycles between two wraps
    task automatic meas;
        do @(posedge mclk); while (wrap !== 1'b1);
        per = 0;
        do begin
            @(posedge mclk);
            per++;
        end while (wrap !== 1'b1);
    endtask
    task automatic t_reset;
        rd(OFF_COUNT);
        chk("count at reset", 32'h0000_FFFF, rv);
        rd(8'h10);
        chk("unmapped read resp", 32'(RESP_SLVERR), 32'(rr));
        wr(8'h10, 32'h5);
        chk("unmapped write resp", 32'(RESP_SLVERR), 32'(rr));
        wstrb <= 4'h1;
        wr(OFF_COUNT, 32'h0000_1234);
        wstrb <= 4'hF;
        rd(OFF_COUNT);
        chk("byte-lane count write", 32'h0000_FF34, rv);
        $display("test reset done");
    endtask
    task automatic t_interval;
        wr(OFF_MODE, 32'(MODE_INTERVAL));
        wr(OFF_COUNT, 32'h4);
        rd(OFF_COUNT);
        chk("count after stopped write", 32'h4, rv);
        w0 = wraps;
        f0 = flips;
        wr(OFF_CTRL, RUN | PULSE);
        meas();
        chk("period n=4", 32'h5, 32'(per));
        wr(OFF_COUNT, 32'h9);
        rd(OFF_STAT);
        chk("reload after running write", 32'h9, rv & 32'h0000_FFFF);
        meas();
        chk("period after reload", 32'hA, 32'(per));
        wr(OFF_CTRL, 32'h0);
        repeat (4) @(posedge mclk);
        chk("pin flips per wrap", 32'(wraps - w0), 32'(flips - f0));
        rd(OFF_COUNT);
        a = rv;
        repeat (20) @(posedge mclk);
        rd(OFF_COUNT);
        chk("count while stopped", a, rv);
        $display("test interval done");
    endtask
    task automatic t_sources;
        int mult[4] = '{1, 8, 32, 128};
        for (int s = 0; s < 4; s++) begin
            wr(OFF_COUNT, 32'h2);
            wr(OFF_CTRL, RUN | (32'(s) << CTRL_SRC_LO));
            meas();
            chk("period per source", 32'(3 * mult[s]), 32'(per));
            wr(OFF_CTRL, 32'h0);
        end
        $display("test sources done");
    endtask
    task automatic t_gate;
        wr(OFF_COUNT, 32'h0100);
        wr(OFF_CTRL, RUN | GATE);
        rd(OFF_COUNT);
        a = rv;
        repeat (20) @(posedge mclk);
        rd(OFF_COUNT);
        chk("count with gate shut", a, rv);
        pins_u.set_lvl(1'b1);
        repeat (8) @(posedge mclk);
        rd(OFF_COUNT);
        chk("count with gate open", 32'h1, 32'(rv !== a));
        wr(OFF_CTRL, 32'h0);
        pins_u.set_lvl(1'b0);
        $display("test gate done");
    endtask
    // event mode: reload, free-run, up, pin direction, neighbour source
    task automatic t_event;
        wr(OFF_MODE, 32'(MODE_EVENT));
        wr(OFF_COUNT, 32'h3);
        wr(OFF_CTRL, RUN);
        pins_u.pulse(3);
        rd(OFF_COUNT);
        chk("down count after 3", 32'h0, rv);
        w0 = wraps;
        pins_u.pulse(1);
        rd(OFF_COUNT);
        chk("reload on underflow", 32'h3, rv);
        chk("one wrap", 32'h1, 32'(wraps - w0));
        wr(OFF_CTRL, 32'h0);
        wr(OFF_COUNT, 32'h1);
        wr(OFF_CTRL, RUN | FREE);
        pins_u.pulse(2);
        rd(OFF_COUNT);
        chk("free-run wrap", 32'h0000_FFFF, rv);
        wr(OFF_CTRL, 32'h0);
        wr(OFF_COUNT, 32'h0000_FFFE);
        w0 = wraps;
        wr(OFF_CTRL, RUN | UP);
        pins_u.pulse(2);
        rd(OFF_COUNT);
        chk("up reload", 32'h0000_FFFE, rv);
        chk("up wrap", 32'h1, 32'(wraps - w0));
        wr(OFF_CTRL, 32'h0);
        wr(OFF_COUNT, 32'h5);
        wr(OFF_CTRL, RUN | DIRP);
        pins_u.pulse(1);
        rd(OFF_COUNT);
        chk("pin direction up", 32'h6, rv);
        pins_u.set_dir(1'b0);
        pins_u.pulse(2);
        rd(OFF_COUNT);
        chk("pin direction down", 32'h4, rv);
        wr(OFF_CTRL, RUN | (32'(EVT_NEIGH) << CTRL_SRC_LO));
        pins_u.tick(1'b1);
        pins_u.tick(1'b0);
        rd(OFF_COUNT);
        chk("neighbour source", 32'h3, rv);
        wr(OFF_CTRL, RUN | (32'(EVT_GRP2) << CTRL_SRC_LO));
        pins_u.tick(1'b0);
        wr(OFF_CTRL, RUN | (32'h1 << CTRL_EDGE_FALL));
        pins_u.pulse(1);
        rd(OFF_COUNT);
        chk("group-two and falling edge", 32'h1, rv);
        $display("test event done");
    endtask
    initial begin
        rst_b = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        wstrb = 4'hF;
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (2) @(posedge mclk);
        t_reset;
        t_interval;
        t_sources;
        t_gate;
        t_event;
        chk("request per wrap", 32'(wraps), 32'(irqs));
        give_verdict;
    end
endmodule // gp_timer_tb_top
